//--- include/cis_pkg.sv
// Constants, types and carriers shared by the interrupt sequencer
package cis_pkg;

  // Clock and timing, in nanoseconds and derived cycle counts
  localparam int CIS_CLK_PERIOD_NS = 5;
  localparam int CIS_ENTRY_NS = 20;
  localparam int CIS_WAKE_NS = 20;
  localparam int CIS_RETURN_NS = 20;
  localparam int CIS_ENTRY_CYC = (CIS_ENTRY_NS + CIS_CLK_PERIOD_NS - 1) / CIS_CLK_PERIOD_NS;
  localparam int CIS_WAKE_CYC = (CIS_WAKE_NS + CIS_CLK_PERIOD_NS - 1) / CIS_CLK_PERIOD_NS;
  localparam int CIS_RETURN_CYC = CIS_RETURN_NS / CIS_CLK_PERIOD_NS;

  // Widths
  localparam int CIS_PC_W = 13;
  localparam int CIS_SP_W = 11;
  localparam int CIS_MAX_SRC = 32;

  // Register byte offsets
  localparam logic [7:0] CIS_OFF_CTRL = 8'h00;
  localparam logic [7:0] CIS_OFF_ENABLE = 8'h04;
  localparam logic [7:0] CIS_OFF_FLAGS = 8'h08;
  localparam logic [7:0] CIS_OFF_STATUS = 8'h0C;
  localparam logic [7:0] CIS_OFF_SP = 8'h10;
  localparam logic [7:0] CIS_OFF_PC = 8'h14;
  localparam logic [7:0] CIS_OFF_SEQ = 8'h18;

  // Field positions
  localparam int CIS_CTRL_RELOC_BIT = 0;
  localparam int CIS_STATUS_GIE_BIT = 7;

  // Reset values and vector stride
  localparam logic [7:0] CIS_STATUS_RST = 8'h00;
  localparam logic [CIS_SP_W-1:0] CIS_SP_RST = 11'h000;
  localparam logic [CIS_PC_W-1:0] CIS_VEC_STRIDE = 13'h0002;

  typedef enum logic [2:0] {
    ST_RESET_VEC,
    ST_IDLE,
    ST_WAKE,
    ST_ENTRY,
    ST_RETURN
  } cis_phase_type;

  // Pipeline view of the instruction stream
  typedef struct packed {
    logic boundary;
    logic is_sei;
    logic is_cli;
    logic is_return_from_interrupt;
    logic sleeping;
    logic [CIS_PC_W-1:0] pc;
  } cis_instr_type;

  // Stack memory port
  typedef struct packed {
    logic we;
    logic re;
    logic [15:0] addr;
    logic [7:0] wdata;
  } cis_stack_type;

  // Program counter load towards the pipeline
  typedef struct packed {
    logic valid;
    logic from_return_from_interrupt;
    logic [5:0] index;
    logic [CIS_PC_W-1:0] addr;
  } cis_pcload_type;

  // Whole state of the sequencer
  typedef struct packed {
    cis_phase_type phase;
    logic [2:0] cnt;
    logic [7:0] status;
    logic reloc;
    logic [CIS_MAX_SRC-1:0] enable;
    logic [CIS_MAX_SRC-1:0] flags;
    logic [CIS_SP_W-1:0] sp;
    logic [5:0] win_idx;
    logic [CIS_PC_W-1:0] ret_pc;
    logic [7:0] pop_hi;
    logic hold_one;
    logic fuse_boot;
    logic lock_app;
    logic lock_boot;
    logic [31:0] prdata;
    cis_pcload_type pcl;
    cis_stack_type stk;
  } cis_state_type;

endpackage : cis_pkg

//--- hdl/cis_sequencer.sv
// Interrupt and reset vectoring sequencer with APB register access
// Notes on behaviour
// - Request needs own enable and global enable
// - Lowest vector index wins; reset first
// - Relocate select moves vectors to boot start
// - Boot reset fuse moves reset vector
// - Taking interrupt clears global enable
// - Software may re-enable inside handler, nesting
// - Return from interrupt sets global enable
// - Flag cleared by hardware when vectored
// - Write one clears flag, zero keeps
// - Flags set even while disabled, stay pending
// - Level sources request only while present
// - One main instruction after return first
// - Status register never saved nor restored
// - Disable instruction blocks same-cycle interrupt
// - Instruction after enable runs first
// - Entry lasts four cycles, pushes counter
// - Multi-cycle instruction completes before entry
// - Waking from sleep adds four cycles
// - Return lasts four cycles, pops two bytes
// - Boot lock bits can block interrupts
// - Program counter is thirteen bits
// - Push decrements stack pointer by two
// - Global enable is status bit seven
`timescale 1ns/10ps
module cis_sequencer #(
  parameter int N_SRC = 8,
  parameter logic [31:0] FLAG_MASK = 32'h0000_00FF,
  parameter logic [12:0] BOOT_START = 13'h1C00
) (
  input wire logic pclk, // System clock
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic [N_SRC-1:0] src_event, // Source events or levels
  input wire cis_pkg::cis_instr_type instr, // Instruction stream view
  input wire logic boot_reset_fuse, // Fuse strap, high when programmed
  input wire logic app_boot_lock_bit, // Lock strap, high when programmed
  input wire logic boot_section_lock_bit, // Lock strap, high when programmed
  input wire logic [7:0] stk_rdata, // Stack read data, one cycle after re
  output cis_pkg::cis_stack_type stk, // Stack write and read port
  output cis_pkg::cis_pcload_type pc_load, // Program counter load
  output logic irq_busy, // Pipeline stall while sequencing
  output logic wake_req // Enabled request while asleep
);
  import cis_pkg::*;

  localparam logic [31:0] SRC_MASK = 32'((33'h1 << N_SRC) - 33'h1);
  localparam logic [31:0] LEVEL_MASK = SRC_MASK & ~FLAG_MASK;

  // Refuse source counts that the vector index cannot hold
  if (N_SRC < 1 || N_SRC > 31) begin : g_bad_n
    $error("N_SRC must lie between 1 and 31");
  end

  cis_state_type s_reg;
  cis_state_type s_next;
  logic [31:0] src_wide;
  logic [31:0] ev_set;
  logic [31:0] pending;
  logic [31:0] w1c;
  logic [31:0] hw_clr;
  logic gie_eff;
  logic lock_block;
  logic at_point;
  logic take;
  logic apb_setup;
  logic apb_wr;
  logic mapped;

  // Lowest set bit gives the highest priority
  function automatic logic [5:0] first_set(input logic [31:0] v);
    logic [5:0] r;
    r = 6'h00;
    for (int i = 31; i >= 0; i--) begin
      if (v[i]) begin
        r = 6'(i);
      end
    end
    return r;
  endfunction : first_set

  // Vector address from table base and vector index
  function automatic logic [12:0] vec_addr(input logic at_boot, input logic [5:0] idx);
    logic [12:0] base;
    base = at_boot ? BOOT_START : 13'h0000;
    return 13'(base + 13'(idx) * CIS_VEC_STRIDE);
  endfunction : vec_addr

  // Source conditioning and gating
  always_comb begin
    src_wide = 32'(src_event);
    ev_set = src_wide & FLAG_MASK & SRC_MASK;
    pending = ((s_reg.flags & FLAG_MASK) | (src_wide & LEVEL_MASK)) & s_reg.enable & SRC_MASK;
    gie_eff = s_reg.status[CIS_STATUS_GIE_BIT] && !(instr.boundary && instr.is_cli);
    lock_block = (s_reg.lock_app && !s_reg.reloc && instr.pc < BOOT_START)
               || (s_reg.lock_boot && s_reg.reloc && instr.pc >= BOOT_START);
    at_point = instr.boundary || instr.sleeping;
    take = (s_reg.phase == ST_IDLE) && at_point && !(instr.boundary && instr.is_return_from_interrupt)
         && !s_reg.hold_one && gie_eff && (|pending) && !lock_block;
  end

  // APB decode
  always_comb begin
    apb_setup = psel && !penable;
    apb_wr = psel && penable && pwrite;
    mapped = (paddr == CIS_OFF_CTRL) || (paddr == CIS_OFF_ENABLE) || (paddr == CIS_OFF_FLAGS)
          || (paddr == CIS_OFF_STATUS) || (paddr == CIS_OFF_SP) || (paddr == CIS_OFF_PC)
          || (paddr == CIS_OFF_SEQ);
  end

  // Next-state logic for the whole sequencer
  always_comb begin
    s_next = s_reg;
    s_next.pcl.valid = 1'b0;
    s_next.pcl.from_return_from_interrupt = 1'b0;
    s_next.stk.we = 1'b0;
    s_next.stk.re = 1'b0;
    w1c = 32'h0000_0000;
    hw_clr = 32'h0000_0000;

    // Read data captured in the setup cycle
    if (apb_setup) begin
      case (paddr)
        CIS_OFF_CTRL: s_next.prdata = {31'h0, s_reg.reloc};
        CIS_OFF_ENABLE: s_next.prdata = s_reg.enable;
        CIS_OFF_FLAGS: s_next.prdata = (s_reg.flags | (src_wide & LEVEL_MASK)) & SRC_MASK;
        CIS_OFF_STATUS: s_next.prdata = {24'h0, s_reg.status};
        CIS_OFF_SP: s_next.prdata = {21'h0, s_reg.sp};
        CIS_OFF_PC: s_next.prdata = {19'h0, s_reg.ret_pc};
        CIS_OFF_SEQ: s_next.prdata = {16'h0, s_reg.lock_boot, s_reg.lock_app, s_reg.fuse_boot,
                                      s_reg.hold_one, 3'(s_reg.phase), 3'h0, s_reg.win_idx};
        default: s_next.prdata = 32'h0000_0000;
      endcase
    end

    // Register writes at the access edge
    if (apb_wr) begin
      case (paddr)
        CIS_OFF_CTRL: s_next.reloc = pwdata[CIS_CTRL_RELOC_BIT];
        CIS_OFF_ENABLE: s_next.enable = pwdata & SRC_MASK;
        CIS_OFF_FLAGS: w1c = pwdata;
        CIS_OFF_STATUS: s_next.status = pwdata[7:0];
        CIS_OFF_SP: s_next.sp = pwdata[CIS_SP_W-1:0];
        default: s_next.reloc = s_reg.reloc;
      endcase
    end

    // Enable and disable instructions retire at the boundary
    if (instr.boundary && s_reg.phase == ST_IDLE) begin
      s_next.hold_one = instr.is_sei;
      if (instr.is_sei) begin
        s_next.status[CIS_STATUS_GIE_BIT] = 1'b1;
      end
      if (instr.is_cli) begin
        s_next.status[CIS_STATUS_GIE_BIT] = 1'b0;
      end
    end

    case (s_reg.phase)
      ST_RESET_VEC: begin
        // Straps are caught here, after the reset has released
        s_next.fuse_boot = boot_reset_fuse;
        s_next.lock_app = app_boot_lock_bit;
        s_next.lock_boot = boot_section_lock_bit;
        s_next.pcl.valid = 1'b1;
        s_next.pcl.index = 6'h00;
        s_next.pcl.addr = vec_addr(boot_reset_fuse, 6'h00);
        s_next.phase = ST_IDLE;
      end
      ST_IDLE: begin
        if (instr.boundary && instr.is_return_from_interrupt) begin
          s_next.phase = ST_RETURN;
          s_next.cnt = 3'h0;
        end else if (take) begin
          s_next.win_idx = 6'(first_set(pending) + 6'h01);
          s_next.ret_pc = instr.pc;
          s_next.status[CIS_STATUS_GIE_BIT] = 1'b0;
          s_next.cnt = 3'h0;
          s_next.phase = instr.sleeping ? ST_WAKE : ST_ENTRY;
        end
      end
      ST_WAKE: begin
        // Extra wake latency before the normal entry
        s_next.cnt = 3'(s_reg.cnt + 3'h1);
        if (s_reg.cnt == 3'(CIS_WAKE_CYC - 1)) begin
          s_next.cnt = 3'h0;
          s_next.phase = ST_ENTRY;
        end
      end
      ST_ENTRY: begin
        s_next.cnt = 3'(s_reg.cnt + 3'h1);
        if (s_reg.cnt == 3'h0) begin
          // Low byte first, stack grows downward
          s_next.stk.we = 1'b1;
          s_next.stk.addr = 16'(s_reg.sp);
          s_next.stk.wdata = s_reg.ret_pc[7:0];
          s_next.sp = 11'(s_reg.sp - 11'h001);
        end
        if (s_reg.cnt == 3'h1) begin
          s_next.stk.we = 1'b1;
          s_next.stk.addr = 16'(s_reg.sp);
          s_next.stk.wdata = {3'h0, s_reg.ret_pc[12:8]};
          s_next.sp = 11'(s_reg.sp - 11'h001);
        end
        if (s_reg.cnt == 3'(CIS_ENTRY_CYC - 1)) begin
          s_next.pcl.valid = 1'b1;
          s_next.pcl.index = s_reg.win_idx;
          s_next.pcl.addr = vec_addr(s_reg.reloc, s_reg.win_idx);
          hw_clr = 32'(33'h1 << (s_reg.win_idx - 6'h01)) & FLAG_MASK;
          s_next.cnt = 3'h0;
          s_next.phase = ST_IDLE;
        end
      end
      ST_RETURN: begin
        s_next.cnt = 3'(s_reg.cnt + 3'h1);
        if (s_reg.cnt == 3'h0) begin
          // High byte sits just above the stack pointer
          s_next.stk.re = 1'b1;
          s_next.stk.addr = 16'(11'(s_reg.sp + 11'h001));
        end
        if (s_reg.cnt == 3'h1) begin
          s_next.stk.re = 1'b1;
          s_next.stk.addr = 16'(11'(s_reg.sp + 11'h002));
        end
        if (s_reg.cnt == 3'h2) begin
          s_next.pop_hi = stk_rdata;
        end
        if (s_reg.cnt == 3'(CIS_RETURN_CYC - 1)) begin
          s_next.ret_pc = {s_reg.pop_hi[4:0], stk_rdata};
          s_next.pcl.valid = 1'b1;
          s_next.pcl.from_return_from_interrupt = 1'b1;
          s_next.pcl.index = s_reg.win_idx;
          s_next.pcl.addr = {s_reg.pop_hi[4:0], stk_rdata};
          s_next.sp = 11'(s_reg.sp + 11'h002);
          s_next.status[CIS_STATUS_GIE_BIT] = 1'b1;
          s_next.hold_one = 1'b1;
          s_next.cnt = 3'h0;
          s_next.phase = ST_IDLE;
        end
      end
      default: begin
        s_next.phase = ST_IDLE;
        s_next.cnt = 3'h0;
      end
    endcase

    // New events win over any clear in the same cycle
    s_next.flags = ((s_reg.flags & ~w1c & ~hw_clr) | ev_set) & FLAG_MASK & SRC_MASK;
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
      s_reg.phase <= ST_RESET_VEC;
      s_reg.status <= CIS_STATUS_RST;
      s_reg.sp <= CIS_SP_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs
  always_comb begin
    prdata = s_reg.prdata;
    pready = psel && penable;
    pslverr = psel && penable && !mapped;
    stk = s_reg.stk;
    pc_load = s_reg.pcl;
    irq_busy = (s_reg.phase != ST_IDLE);
    wake_req = instr.sleeping && (|pending) && s_reg.status[CIS_STATUS_GIE_BIT];
  end

  // Checks on the sequencing behaviour
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence entry_run;
    (s_reg.phase == ST_ENTRY) [*4] ##1 pc_load.valid;
  endsequence

  sequence return_run;
    (s_reg.phase == ST_RETURN) [*4] ##1 (pc_load.valid && pc_load.from_return_from_interrupt);
  endsequence

  chk_take_gated: assert property (take |-> s_reg.status[CIS_STATUS_GIE_BIT]
    && !instr.is_cli && ((pending & s_reg.enable) != 32'h0))
    else $error("interrupt taken without both enables");

  chk_gie_clear: assert property (take && !apb_wr |=> !s_reg.status[CIS_STATUS_GIE_BIT])
    else $error("global enable not cleared on entry");

  chk_entry_time: assert property (take && !instr.sleeping |-> ##1 entry_run)
    else $error("entry did not load vector after four cycles");

  chk_wake_time: assert property (take && instr.sleeping |-> ##5 entry_run)
    else $error("wake entry did not take four extra cycles");

  chk_push_two: assert property (take && !instr.sleeping && !apb_wr ##1 !apb_wr [*2]
    |=> s_reg.sp == 11'($past(s_reg.sp, 3) - 11'h002))
    else $error("stack pointer not lowered by two on push");

  chk_return_time: assert property (s_reg.phase == ST_IDLE && instr.boundary && instr.is_return_from_interrupt
    |-> ##1 return_run ##0 s_reg.status[CIS_STATUS_GIE_BIT])
    else $error("return did not finish in four cycles with enable set");

  chk_hold_one: assert property (s_reg.hold_one |-> !take)
    else $error("interrupt taken before one main instruction");

  chk_vec_addr: assert property (pc_load.valid && !pc_load.from_return_from_interrupt && pc_load.index != 6'h00
    |-> pc_load.addr == vec_addr(s_reg.reloc, pc_load.index))
    else $error("vector address wrong for table base");

  chk_flag_sticky: assert property (ev_set != 32'h0
    |=> (s_reg.flags & $past(ev_set)) == $past(ev_set))
    else $error("flag event lost");

  chk_flag_w1c: assert property (apb_wr && paddr == CIS_OFF_FLAGS && ev_set == 32'h0
    |=> (s_reg.flags & $past(pwdata)) == 32'h0)
    else $error("write one did not clear flag");

  // Two pushes, low byte of the counter first
  sequence push_pair;
    (stk.we && stk.wdata == 8'($past(instr.pc, 2))) ##1
    (stk.we && stk.wdata == {3'h0, 5'($past(instr.pc, 3) >> 8)});
  endsequence

  // Two pops, high byte first, just above the stack pointer
  sequence pop_pair;
    (stk.re && stk.addr == 16'(11'(s_reg.sp + 11'h001))) ##1
    (stk.re && stk.addr == 16'(11'(s_reg.sp + 11'h002)));
  endsequence

  // Stack traffic of entry and return
  chk_push_bytes: assert property (take && !instr.sleeping |-> ##2 push_pair)
    else $error("counter bytes not pushed in order");

  chk_pop_bytes: assert property (s_reg.phase == ST_IDLE && instr.boundary
    && instr.is_return_from_interrupt |-> ##2 pop_pair)
    else $error("counter bytes not popped in order");

  chk_pop_two: assert property (s_reg.phase == ST_IDLE && instr.boundary
    && instr.is_return_from_interrupt |-> ##5 s_reg.sp == 11'($past(s_reg.sp, 5) + 11'h002))
    else $error("stack pointer not raised by two on return");

  // Instruction-boundary rules
  chk_cli_clear: assert property (s_reg.phase == ST_IDLE && instr.boundary
    && instr.is_cli && !apb_wr |=> !s_reg.status[CIS_STATUS_GIE_BIT])
    else $error("disable instruction left global enable set");

  chk_sei_hold: assert property (s_reg.phase == ST_IDLE && instr.boundary
    && instr.is_sei |=> s_reg.hold_one)
    else $error("enable instruction did not hold off one boundary");

  chk_busy_entry: assert property (take |=> irq_busy)
    else $error("pipeline not stalled on entry");

  // Reset vector and flag service
  chk_reset_vec: assert property (pc_load.valid && pc_load.index == 6'h00
    |-> pc_load.addr == (s_reg.fuse_boot ? BOOT_START : 13'h0000))
    else $error("reset vector ignores boot fuse");

  chk_flag_served: assert property (pc_load.valid && pc_load.index != 6'h00
    && !pc_load.from_return_from_interrupt && $past(ev_set) == 32'h0
    |-> !s_reg.flags[5'(pc_load.index - 6'h01)])
    else $error("served flag not cleared");

endmodule : cis_sequencer

//--- tb/cis_stack_model.sv
// Behavioural stack memory on the stack port of the sequencer
`timescale 1ns/10ps
module cis_stack_model (
  input wire logic pclk, // System clock
  input wire cis_pkg::cis_stack_type stk, // Stack port from the sequencer
  output logic [7:0] stk_rdata // Read data, one cycle after a read strobe
);
  import cis_pkg::*;
  logic [7:0] mem [0:255];
  initial stk_rdata = 8'h00;
  // Writes land at the edge; a read answers one edge later
  // Outside a read the line flips, so stale data never looks valid
  always @(posedge pclk) begin
    if (stk.we) begin
      mem[stk.addr[7:0]] <= stk.wdata;
    end
    if (stk.re) begin
      stk_rdata <= mem[stk.addr[7:0]];
    end else begin
      stk_rdata <= ~stk_rdata;
    end
  end
endmodule : cis_stack_model

//--- tb/tb.sv
// Self-checking bench for the interrupt sequencer
`timescale 1ns/10ps
module tb;
  import cis_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, irq_busy, wake_req, er, wk;
  logic [7:0] src_event = 8'h00;
  logic [7:0] stk_rdata;
  cis_instr_type instr = '0;
  cis_stack_type stk;
  cis_pcload_type pc_load, ld;
  logic [31:0] rd;
  logic bz;
  logic fuse_strap = 1'b0;
  logic lock_strap = 1'b0;
  int err_total = 0;
  int comparisons = 0;
  int lat;

  // Clock at 200 MHz
  always #2.5 pclk = ~pclk;

  // Source 7 is level-type, the rest are flag-type
  cis_sequencer #(.FLAG_MASK(32'h0000_007F)) dut_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .src_event(src_event), .instr(instr),
    .boot_reset_fuse(fuse_strap), .app_boot_lock_bit(lock_strap), .boot_section_lock_bit(1'b0),
    .stk_rdata(stk_rdata), .stk(stk), .pc_load(pc_load), .irq_busy(irq_busy),
    .wake_req(wake_req));

  cis_stack_model stk_u (.pclk(pclk), .stk(stk), .stk_rdata(stk_rdata));

  // Comparison of one value
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(what, exp, rd);
  endtask : rdchk

  // One-cycle source events
  task automatic ev(input logic [7:0] b);
    @(posedge pclk);
    src_event <= b;
    @(posedge pclk);
    src_event <= 8'h00;
  endtask : ev

  // Boundary (or sleep) with qualifiers {return_from_interrupt, cli, sei}; lat is edges to the vector load
  task automatic run(input logic [12:0] pc, input logic [2:0] k, input logic slp);
    @(posedge pclk);
    instr <= '{boundary: !slp, is_sei: k[0], is_cli: k[1], is_return_from_interrupt: k[2],
      sleeping: slp, pc: pc};
    #1;
    wk = wake_req;
    @(posedge pclk);
    instr <= '0;
    lat = 0;
    for (int n = 1; n <= 14; n++) begin
      #1;
      if (n == 1) begin
        bz = irq_busy;
      end
      if (pc_load.valid === 1'b1 && lat == 0) begin
        lat = n;
        ld = pc_load;
      end
      @(posedge pclk);
    end
  endtask : run

  task automatic test_entry;
    ev(8'h0C);
    rdchk("flags while off", CIS_OFF_FLAGS, 32'h0000_000C);
    run(13'h1ABC, 3'b000, 1'b0);
    chk("take while off", 0, lat);
    chk("busy while off", 0, bz);
    apb(1'b1, CIS_OFF_ENABLE, 32'h0000_00FF);
    apb(1'b1, CIS_OFF_STATUS, 32'h0000_0083);
    run(13'h1ABC, 3'b000, 1'b0);
    chk("entry latency", 1 + CIS_ENTRY_CYC, lat);
    chk("busy in entry", 1, bz);
    chk("vector", 32'h0000_0006, ld.addr);
    chk("index", 32'h0000_0003, ld.index);
    rdchk("status on entry", CIS_OFF_STATUS, 32'h0000_0003);
    rdchk("flag after entry", CIS_OFF_FLAGS, 32'h0000_0008);
    rdchk("sp after push", CIS_OFF_SP, 32'h0000_01FE);
    chk("pushed low", 8'hBC, stk_u.mem[8'h00]);
    chk("pushed high", 8'h1A, stk_u.mem[8'hFF]);
    $display("test entry done");
  endtask : test_entry

  task automatic test_return;
    apb(1'b1, CIS_OFF_STATUS, 32'h0000_0001);
    run(13'h0000, 3'b100, 1'b0);
    chk("return latency", 1 + CIS_RETURN_CYC, lat);
    chk("return load", 1, ld.from_return_from_interrupt);
    chk("popped pc", 32'h0000_1ABC, ld.addr);
    rdchk("status on return", CIS_OFF_STATUS, 32'h0000_0081);
    rdchk("sp after pop", CIS_OFF_SP, 32'h0000_0200);
    run(13'h0040, 3'b000, 1'b0);
    chk("take after return", 0, lat);
    run(13'h0041, 3'b000, 1'b0);
    chk("pending vector", 32'h0000_0008, ld.addr);
    ev(8'h01);
    apb(1'b1, CIS_OFF_STATUS, 32'h0000_0080);
    run(13'h0050, 3'b000, 1'b0);
    chk("nested vector", 32'h0000_0002, ld.addr);
    rdchk("sp nested", CIS_OFF_SP, 32'h0000_01FC);
    $display("test return done");
  endtask : test_return

  task automatic test_cli;
    ev(8'h20);
    apb(1'b1, CIS_OFF_STATUS, 32'h0000_0080);
    run(13'h0060, 3'b010, 1'b0);
    chk("take with disable", 0, lat);
    apb(1'b1, CIS_OFF_FLAGS, 32'h0000_0000);
    rdchk("flag kept", CIS_OFF_FLAGS, 32'h0000_0020);
    apb(1'b1, CIS_OFF_FLAGS, 32'h0000_0020);
    rdchk("flag cleared", CIS_OFF_FLAGS, 32'h0000_0000);
    $display("test disable done");
  endtask : test_cli

  task automatic test_sei;
    apb(1'b1, CIS_OFF_CTRL, 32'h0000_0001);
    ev(8'h80);
    apb(1'b1, CIS_OFF_STATUS, 32'h0000_0080);
    run(13'h006F, 3'b000, 1'b0);
    chk("level vanished", 0, lat);
    apb(1'b1, CIS_OFF_STATUS, 32'h0000_0000);
    @(posedge pclk);
    src_event <= 8'h80;
    rdchk("level live", CIS_OFF_FLAGS, 32'h0000_0080);
    run(13'h0070, 3'b001, 1'b0);
    chk("take at enable", 0, lat);
    run(13'h0071, 3'b000, 1'b0);
    chk("take after enable", 0, lat);
    run(13'h0072, 3'b000, 1'b0);
    chk("moved vector", 32'h0000_1C10, ld.addr);
    ev(8'h40);
    apb(1'b1, CIS_OFF_STATUS, 32'h0000_0080);
    run(13'h0080, 3'b000, 1'b1);
    chk("wake request", 1, wk);
    chk("wake latency", 1 + CIS_WAKE_CYC + CIS_ENTRY_CYC, lat);
    chk("wake vector", 32'h0000_1C0E, ld.addr);
    apb(1'b0, 8'h1C, 32'h0000_0000);
    chk("unmapped error", 1, er);
    chk("unmapped data", 32'h0000_0000, rd);
    $display("test enable and sleep done");
  endtask : test_sei

  // Mid-run reset with the boot fuse and the application lock programmed
  task automatic test_boot;
    @(posedge pclk);
    presetn <= 1'b0;
    fuse_strap <= 1'b1;
    lock_strap <= 1'b1;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1;
    chk("boot reset load", 1, pc_load.valid);
    chk("boot reset vector", 32'h0000_1C00, pc_load.addr);
    apb(1'b1, CIS_OFF_ENABLE, 32'h0000_0002);
    ev(8'h02);
    apb(1'b1, CIS_OFF_STATUS, 32'h0000_0080);
    run(13'h0100, 3'b000, 1'b0);
    chk("take while locked", 0, lat);
    run(13'h1C20, 3'b000, 1'b0);
    chk("take in boot area", 32'h0000_0004, ld.addr);
    $display("test boot and lock done");
  endtask : test_boot

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up

  // Watchdog far beyond the few hundred cycles the tests need
  initial begin
    #50000;
    err_total++;
    wrap_up();
  end

  // Reset, reset vector, then the scenarios
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1;
    chk("reset load", 1, pc_load.valid);
    chk("reset vector", 32'h0000_0000, pc_load.addr);
    chk("reset index", 32'h0000_0000, pc_load.index);
    rdchk("status reset", CIS_OFF_STATUS, 32'h0000_0000);
    rdchk("sp reset", CIS_OFF_SP, 32'h0000_0000);
    apb(1'b1, CIS_OFF_SP, 32'h0000_0200);
    $display("test reset done");
    test_entry();
    test_return();
    test_cli();
    test_sei();
    test_boot();
    wrap_up();
  end
endmodule : tb
